// *** src/dcf_top.sv ***
// flag and read timing core of a deep buffer, standard and fall-through
`timescale 1ns/100ps
module dcf_top
	import dcf_pkg::*;
#(
	parameter int DEPTH = DEF_DEPTH,
	parameter int WIDTH = DEF_WIDTH
) (
	input  wire logic             mclk,
	input  wire logic             rst,
	input  wire logic             master_reset_n,
	input  wire logic             timing_mode_select_serial_in,
	input  wire logic             offset_default_sel_load,
	input  wire logic             offset_default_sel_hi,
	input  wire logic             offset_default_sel_lo,
	input  wire logic             write_en_n,
	input  wire logic [WIDTH-1:0] write_word,
	output logic                  write_ready,
	input  wire logic             read_en_n,
	output logic      [WIDTH-1:0] output_word,
	output logic                  empty_flag_n,
	output logic                  full_flag_n,
	output logic                  output_ready_n,
	output logic                  input_ready_n,
	output logic                  almost_empty_n,
	output logic                  almost_full_n,
	output logic                  half_full_n,
	output logic                  fall_through_mode
);

	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam int CW = $clog2(DEPTH + FT_CAP_EXTRA + 1);
	localparam logic [CW-1:0] DEPTH_C = CW'(DEPTH);
	localparam logic [CW-1:0] CAP_FT  = CW'(DEPTH + FT_CAP_EXTRA);
	localparam logic [CW-1:0] HF_STD  = CW'(DEPTH / HALF_DIV + STD_HF_EXTRA);
	localparam logic [CW-1:0] HF_FT   = CW'(DEPTH / HALF_DIV + FT_HF_EXTRA);
	localparam logic [CW-1:0] AE_STD  = CW'(STD_AE_EXTRA);
	localparam logic [CW-1:0] AE_FT   = CW'(FT_AE_EXTRA);
	localparam logic [CW-1:0] ONE_C   = CW'(1);
	localparam logic [AW-1:0] LAST_P  = AW'(DEPTH - 1);

	////////////////////////////////////////////////////////////////////////
	// pin synchronisers and strap capture

	logic [STRAP_W-1:0] strap_d;
	logic [STRAP_W-1:0] strap_q;
	logic [STRAP_W-1:0] strap_p;
	logic [STRAP_W-1:0] strap_r;
	logic               mrst_act;

	assign strap_d = {master_reset_n, timing_mode_select_serial_in,
		offset_default_sel_load, offset_default_sel_hi,
		offset_default_sel_lo};

	dcf_stage #(
		.W   (STRAP_W),
		.N   (SYNC_STAGES),
		.RST (STRAP_RST)
	) u_sync (
		.mclk   (mclk),
		.rst    (rst),
		.d      (strap_d),
		.q      (strap_q),
		.q_prev (strap_p)
	);

	// bits taken only once the last two stages agree
	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
			strap_r <= STRAP_RST;
		else
		begin
			for (int b = 0; b < STRAP_W; b++)
			begin
				if (strap_q[b] == strap_p[b])
					strap_r[b] <= strap_q[b];
			end
		end
	end

	assign mrst_act = !strap_r[STRAP_MRST];

	dcf_mode_e        mode_r;
	logic [OFS_W-1:0] n_r;
	logic [OFS_W-1:0] m_r;
	logic             ft;

	// offsets kept until the next master reset
	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
		begin
			mode_r <= MODE_STD;
			n_r    <= dcf_preset(SEL_RST);
			m_r    <= dcf_preset(SEL_RST);
		end
		else if (mrst_act)
		begin
			mode_r <= strap_r[STRAP_MODE] ? MODE_FALL_THROUGH_MODE : MODE_STD;
			n_r    <= dcf_preset(strap_r[STRAP_LOAD:STRAP_LO]);
			m_r    <= dcf_preset(strap_r[STRAP_LOAD:STRAP_LO]);
		end
	end

	assign ft = (mode_r == MODE_FALL_THROUGH_MODE);

	////////////////////////////////////////////////////////////////////////
	// write path: staging buffer then storage

	logic [WIDTH-1:0] mem_r [DEPTH];
	logic [AW-1:0]    wp_r;
	logic [AW-1:0]    rp_r;
	logic [CW-1:0]    mcnt_r;
	logic [CW-1:0]    tot;
	logic             outv_r;
	logic             full_raw;
	logic             bvalid;
	logic             bready;
	logic [WIDTH-1:0] bdata;
	logic             mem_wr;
	logic             mem_rd;
	logic             rd_req;

	assign tot      = mcnt_r + (ft ? CW'(outv_r) : '0);
	// a word still in the staging buffer already takes a slot
	assign full_raw = ft ? (tot + CW'(bvalid) >= CAP_FT)
		: (tot + CW'(bvalid) >= DEPTH_C);

	dcf_buf2 #(
		.W (WIDTH)
	) u_buf (
		.mclk      (mclk),
		.rst       (rst),
		.clr       (mrst_act),
		.in_valid  (!write_en_n && !full_raw && !mrst_act),
		.in_ready  (write_ready),
		.in_data   (write_word),
		.out_valid (bvalid),
		.out_ready (bready),
		.out_data  (bdata)
	);

	// storage holds depth words; fall-through adds the output register
	assign bready = (mcnt_r != DEPTH_C) && !mrst_act;
	assign mem_wr = bvalid && bready;

	////////////////////////////////////////////////////////////////////////
	// read path

	assign rd_req = !read_en_n;

	always_comb
	begin
		mem_rd = 1'b0;
		if (mcnt_r != '0 && !mrst_act)
		begin
			if (ft)
				mem_rd = !outv_r || rd_req;
			else
				mem_rd = rd_req;
		end
	end

	always_ff @(posedge mclk)
	begin
		if (mem_wr)
			mem_r[wp_r] <= bdata;
	end

	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
		begin
			wp_r   <= '0;
			rp_r   <= '0;
			mcnt_r <= '0;
		end
		else if (mrst_act)
		begin
			wp_r   <= '0;
			rp_r   <= '0;
			mcnt_r <= '0;
		end
		else
		begin
			if (mem_wr)
				wp_r <= (wp_r == LAST_P) ? '0 : wp_r + AW'(1);
			if (mem_rd)
				rp_r <= (rp_r == LAST_P) ? '0 : rp_r + AW'(1);
			if (mem_wr && !mem_rd)
				mcnt_r <= mcnt_r + ONE_C;
			else if (mem_rd && !mem_wr)
				mcnt_r <= mcnt_r - ONE_C;
		end
	end

	// output register; in fall-through it is a storage slot of its own
	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
		begin
			output_word <= '0;
			outv_r      <= 1'b0;
		end
		else if (mrst_act)
		begin
			output_word <= '0;
			outv_r      <= 1'b0;
		end
		else
		begin
			if (mem_rd)
				output_word <= mem_r[rp_r];
			if (ft)
			begin
				if (mem_rd)
					outv_r <= 1'b1;
				else if (rd_req && outv_r)
					outv_r <= 1'b0;
			end
			else
				outv_r <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// flag thresholds

	logic ef_raw_n;
	logic ff_raw_n;
	logic or_raw_n;
	logic ir_raw_n;
	logic ae_raw_n;
	logic af_raw_n;
	logic hf_raw_n;
	logic [CW-1:0] n_c;
	logic [CW-1:0] m_c;

	assign n_c = CW'(n_r);
	assign m_c = CW'(m_r);

	assign ef_raw_n = (tot != '0);
	assign ff_raw_n = !(tot == DEPTH_C);
	assign or_raw_n = !outv_r;
	assign ir_raw_n = (tot == CAP_FT);

	always_comb
	begin
		if (ft)
		begin
			ae_raw_n = (tot >= n_c + AE_FT);
			hf_raw_n = !(tot >= HF_FT);
			af_raw_n = !(tot + m_c >= CAP_FT);
		end
		else
		begin
			ae_raw_n = (tot >= n_c + AE_STD);
			hf_raw_n = !(tot >= HF_STD);
			af_raw_n = !(tot + m_c >= DEPTH_C);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// flag register stages; gating uses the raw count, not these

	logic [2:0] prog_q;
	logic       ef_q;
	logic       ff_q;
	logic       or_q;
	logic       ir_q;

	dcf_stage #(.W(1), .N(EMPTY_STAGES), .RST(1'b0)) u_ef (
		.mclk(mclk), .rst(rst), .d(ef_raw_n), .q(ef_q), .q_prev()
	);

	dcf_stage #(.W(1), .N(FULL_STAGES), .RST(1'b1)) u_ff (
		.mclk(mclk), .rst(rst), .d(ff_raw_n), .q(ff_q), .q_prev()
	);

	dcf_stage #(.W(1), .N(OR_STAGES), .RST(1'b1)) u_or (
		.mclk(mclk), .rst(rst), .d(or_raw_n), .q(or_q), .q_prev()
	);

	dcf_stage #(.W(1), .N(IR_STAGES), .RST(1'b0)) u_ir (
		.mclk(mclk), .rst(rst), .d(ir_raw_n), .q(ir_q), .q_prev()
	);

	dcf_stage #(.W(3), .N(FLAG_STAGES), .RST(3'h3)) u_prog (
		.mclk   (mclk),
		.rst    (rst),
		.d      ({ae_raw_n, af_raw_n, hf_raw_n}),
		.q      (prog_q),
		.q_prev ()
	);

	// unused pair of the inactive mode is held at its idle level
	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
		begin
			empty_flag_n      <= 1'b0;
			full_flag_n       <= 1'b1;
			output_ready_n    <= 1'b1;
			input_ready_n     <= 1'b0;
			almost_empty_n    <= 1'b0;
			almost_full_n     <= 1'b1;
			half_full_n       <= 1'b1;
			fall_through_mode <= 1'b0;
		end
		else
		begin
			empty_flag_n      <= ft ? 1'b0 : ef_q;
			full_flag_n       <= ft ? 1'b1 : ff_q;
			output_ready_n    <= ft ? or_q : 1'b1;
			input_ready_n     <= ft ? ir_q : 1'b0;
			almost_empty_n    <= prog_q[2];
			almost_full_n     <= prog_q[1];
			half_full_n       <= prog_q[0];
			fall_through_mode <= ft;
		end
	end

endmodule

// *** src/dcf_pkg.sv ***
// constants, types and preset offsets for the flag-timing buffer
package dcf_pkg;

	localparam int DEF_DEPTH    = 1024;
	localparam int DEF_WIDTH    = 36;
	localparam int OFS_W        = 10;
	localparam int SYNC_STAGES  = 3;
	localparam int EMPTY_STAGES = 2;
	localparam int FULL_STAGES  = 2;
	localparam int OR_STAGES    = 3;
	localparam int IR_STAGES    = 2;
	localparam int FLAG_STAGES  = 1;
	localparam int STRAP_W      = 5;
	localparam int BUF_ENTRIES  = 2;

	// extra words over the plain threshold in each timing mode, and the divisor for half depth
	localparam int STD_AE_EXTRA  = 1;
	localparam int FT_AE_EXTRA   = 2;
	localparam int STD_HF_EXTRA  = 1;
	localparam int FT_HF_EXTRA   = 2;
	localparam int FT_CAP_EXTRA  = 1;
	localparam int HALF_DIV      = 2;

	// strap vector bit positions
	localparam int STRAP_MRST = 4;
	localparam int STRAP_MODE = 3;
	localparam int STRAP_LOAD = 2;
	localparam int STRAP_HI   = 1;
	localparam int STRAP_LO   = 0;
	localparam logic [STRAP_W-1:0] STRAP_RST = 5'h10;

	typedef enum logic
	{
		MODE_STD  = 1'b0,
		MODE_FALL_THROUGH_MODE = 1'b1
	} dcf_mode_e;

	localparam logic [2:0]       SEL_RST  = 3'h0;
	localparam logic [OFS_W-1:0] OFS_511  = 10'h1FF;
	localparam logic [OFS_W-1:0] OFS_255  = 10'h0FF;
	localparam logic [OFS_W-1:0] OFS_127  = 10'h07F;
	localparam logic [OFS_W-1:0] OFS_63   = 10'h03F;
	localparam logic [OFS_W-1:0] OFS_31   = 10'h01F;
	localparam logic [OFS_W-1:0] OFS_15   = 10'h00F;
	localparam logic [OFS_W-1:0] OFS_7    = 10'h007;
	localparam logic [OFS_W-1:0] OFS_3    = 10'h003;

	// sel = {load, hi, lo}
	function automatic logic [OFS_W-1:0] dcf_preset(input logic [2:0] sel);
		logic [OFS_W-1:0] v;
		v = OFS_127;
		case (sel)
			3'h2: v = OFS_511;
			3'h1: v = OFS_255;
			3'h0: v = OFS_127;
			3'h3: v = OFS_63;
			3'h4: v = OFS_31;
			3'h6: v = OFS_15;
			3'h5: v = OFS_7;
			3'h7: v = OFS_3;
			default: v = OFS_127;
		endcase
		return v;
	endfunction

endpackage

// *** src/dcf_stage.sv ***
// register chain used for flag stages and pin synchronisers
`timescale 1ns/100ps
module dcf_stage #(
	parameter int       W   = 1,
	parameter int       N   = 2,
	parameter logic [W-1:0] RST = '0
) (
	input  wire logic         mclk,
	input  wire logic         rst,
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q,
	output logic      [W-1:0] q_prev
);

	logic [W-1:0] chain_r [N];

	genvar i;
	generate
		for (i = 0; i < N; i++)
		begin : g_st
			always_ff @(posedge mclk or posedge rst)
			begin
				if (rst)
					chain_r[i] <= RST;
				else if (i == 0)
					chain_r[i] <= d;
				else
					chain_r[i] <= chain_r[(i > 0) ? i - 1 : 0];
			end
		end
	endgenerate

	assign q      = chain_r[N-1];
	// for a one-stage chain this is the input itself
	assign q_prev = (N > 1) ? chain_r[(N > 1) ? N - 2 : 0] : d;

endmodule

// *** src/dcf_buf2.sv ***
// two-entry buffer with valid and ready on both sides
`timescale 1ns/100ps
module dcf_buf2
	import dcf_pkg::*;
#(
	parameter int W = DEF_WIDTH
) (
	input  wire logic         mclk,
	input  wire logic         rst,
	input  wire logic         clr,
	input  wire logic         in_valid,
	output logic              in_ready,
	input  wire logic [W-1:0] in_data,
	output logic              out_valid,
	input  wire logic         out_ready,
	output logic      [W-1:0] out_data
);

	logic [W-1:0] ent_r [BUF_ENTRIES];
	logic         wi_r;
	logic         ri_r;
	logic [1:0]   cnt_r;
	logic [1:0]   cnt_nxt;
	logic         push;
	logic         pop;

	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;
	assign out_valid = (cnt_r != 2'h0);
	assign out_data  = ent_r[ri_r];

	always_comb
	begin
		cnt_nxt = cnt_r;
		if (push && !pop)
			cnt_nxt = cnt_r + 2'h1;
		else if (pop && !push)
			cnt_nxt = cnt_r - 2'h1;
	end

	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
		begin
			cnt_r    <= 2'h0;
			wi_r     <= 1'b0;
			ri_r     <= 1'b0;
			in_ready <= 1'b1;
		end
		else if (clr)
		begin
			cnt_r    <= 2'h0;
			wi_r     <= 1'b0;
			ri_r     <= 1'b0;
			in_ready <= 1'b1;
		end
		else
		begin
			cnt_r    <= cnt_nxt;
			// ready as a flop so the writer sees it without a comb path
			in_ready <= (cnt_nxt != 2'(BUF_ENTRIES));
			if (push)
				wi_r <= !wi_r;
			if (pop)
				ri_r <= !ri_r;
		end
	end

	always_ff @(posedge mclk)
	begin
		if (push)
			ent_r[wi_r] <= in_data;
	end

endmodule

// *** verification/dcf_peer.sv ***
// writer and reader model on the far side of the flag-timing buffer
`timescale 1ns/100ps
module dcf_peer (
	input  wire logic        mclk,
	input  wire logic        write_ready,
	output logic             write_en_n,
	output logic      [35:0] write_word,
	output logic             read_en_n
);
	initial
	begin
		write_en_n = 1'b1;
		write_word = 36'h0;
		read_en_n  = 1'b1;
	end
	////////////////////////////////////////////////////////////////////////
	// request held until an edge sees ready high
	task automatic put(input logic [35:0] w);
		logic rdy;
		@(posedge mclk);
		#1;
		write_en_n = 1'b0;
		write_word = w;
		// ready taken while settled, as the edge will see it
		@(negedge mclk);
		rdy = write_ready;
		@(posedge mclk);
		while (rdy !== 1'b1)
		begin
			@(negedge mclk);
			rdy = write_ready;
			@(posedge mclk);
		end
		#1;
		write_en_n = 1'b1;
		// released data shows the inverse, never a stale copy
		write_word = ~w;
	endtask
	// one read request per call, every word asked for
	task automatic take();
		@(posedge mclk);
		#1;
		read_en_n = 1'b0;
		@(posedge mclk);
		#1;
		read_en_n = 1'b1;
	endtask
endmodule

// *** verification/dcf_check_properties.sv ***
// port assertions for the flag-timing buffer
`timescale 1ns/100ps
module dcf_check #(
	parameter int WIDTH = 36
) (
	input wire logic             mclk,
	input wire logic             rst,
	input wire logic             master_reset_n,
	input wire logic             write_en_n,
	input wire logic             write_ready,
	input wire logic             read_en_n,
	input wire logic [WIDTH-1:0] output_word,
	input wire logic             empty_flag_n,
	input wire logic             full_flag_n,
	input wire logic             output_ready_n,
	input wire logic             input_ready_n,
	input wire logic             almost_empty_n,
	input wire logic             almost_full_n,
	input wire logic             fall_through_mode
);
	logic [3:0] mr_r;
	logic [4:0] since_wr_r;
	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst || !master_reset_n)
			mr_r <= 4'h0;
		else if (mr_r != 4'hF)
			mr_r <= mr_r + 4'h1;
	end
	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
			since_wr_r <= 5'h1F;
		else if (!write_en_n && write_ready)
			since_wr_r <= 5'h00;
		else if (since_wr_r != 5'h1F)
			since_wr_r <= since_wr_r + 5'h01;
	end
	////////////////////////////////////////////////////////////////////////
	default clocking @(posedge mclk);
	endclocking
	// flags are unsettled while the master reset pipeline runs
	default disable iff (rst || mr_r != 4'hF);
	a_std_ready_idle: assert property (
		!fall_through_mode |-> output_ready_n && !input_ready_n)
		else $error("ready flags active in standard mode");
	a_ft_empty_idle: assert property (
		fall_through_mode |-> !empty_flag_n && full_flag_n)
		else $error("empty or full flag active in fall-through");
	a_empty_rise_late: assert property (
		$rose(empty_flag_n) |-> since_wr_r >= 5'h02 && since_wr_r <= 5'h14)
		else $error("empty flag rose at wrong distance from write");
	a_full_fall_late: assert property (
		$fell(full_flag_n) |-> since_wr_r >= 5'h02 && since_wr_r <= 5'h14)
		else $error("full flag fell at wrong distance from write");
	a_ready_fall_late: assert property (
		$fell(output_ready_n) |-> since_wr_r >= 5'h03 && since_wr_r <= 5'h14)
		else $error("output ready fell at wrong distance from write");
	a_empty_almost: assert property (
		!fall_through_mode && !empty_flag_n |-> !almost_empty_n)
		else $error("almost empty high while empty");
	a_notready_almost: assert property (
		fall_through_mode && output_ready_n |-> !almost_empty_n)
		else $error("almost empty high while no word ready");
	a_full_almost: assert property (
		!full_flag_n |-> !almost_full_n)
		else $error("almost full high while full");
	a_inready_almost: assert property (
		input_ready_n |-> !almost_full_n)
		else $error("almost full high while input not ready");
	a_std_empty_hold: assert property (
		!fall_through_mode && !empty_flag_n && since_wr_r > 5'h0C
		&& !read_en_n |=> $stable(output_word))
		else $error("read while empty changed the output");
	a_ft_empty_hold: assert property (
		fall_through_mode && output_ready_n && since_wr_r > 5'h0C
		&& !read_en_n |=> $stable(output_word))
		else $error("read with no word ready changed the output");
	c_full: cover property ($fell(full_flag_n));
	c_inready: cover property ($rose(input_ready_n));
	c_ready: cover property ($fell(output_ready_n));
endmodule

// *** verification/test_dual_clock_fifo_flag_timing_modes.sv ***
// self-checking bench for the flag-timing buffer in both modes
`timescale 1ns/100ps
module test_dual_clock_fifo_flag_timing_modes;
	import dcf_pkg::*;
	localparam int D = 16;
	logic        mclk, rst, master_reset_n, timing_mode_select_serial_in;
	logic        offset_default_sel_load, offset_default_sel_hi;
	logic        offset_default_sel_lo, write_en_n, write_ready, read_en_n;
	logic [35:0] write_word, output_word;
	logic        empty_flag_n, full_flag_n, output_ready_n, input_ready_n;
	logic        almost_empty_n, almost_full_n, half_full_n;
	logic        fall_through_mode;
	int          fail_count;
	int          tests_run;

	// small depth keeps every threshold reachable in a short run
	dcf_top #(.DEPTH(D), .WIDTH(36)) dut (.mclk(mclk), .rst(rst),
		.master_reset_n(master_reset_n),
		.timing_mode_select_serial_in(timing_mode_select_serial_in),
		.offset_default_sel_load(offset_default_sel_load),
		.offset_default_sel_hi(offset_default_sel_hi),
		.offset_default_sel_lo(offset_default_sel_lo),
		.write_en_n(write_en_n), .write_word(write_word),
		.write_ready(write_ready), .read_en_n(read_en_n),
		.output_word(output_word), .empty_flag_n(empty_flag_n),
		.full_flag_n(full_flag_n), .output_ready_n(output_ready_n),
		.input_ready_n(input_ready_n), .almost_empty_n(almost_empty_n),
		.almost_full_n(almost_full_n), .half_full_n(half_full_n),
		.fall_through_mode(fall_through_mode));
	dcf_peer peer (.mclk(mclk), .write_ready(write_ready),
		.write_en_n(write_en_n), .write_word(write_word),
		.read_en_n(read_en_n));
	////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic ok, input string what);
		tests_run++;
		if (ok !== 1'b1)
		begin
			fail_count++;
			$display("unexpected at %0t: %s", $time, what);
		end
	endtask
	// flag pipelines are a few cycles deep; twelve covers the longest
	task automatic settle();
		repeat (12) @(posedge mclk);
		#1;
	endtask
	task automatic flags(input logic ft, input int n, input int c);
		logic [6:0] e;
		if (ft)
			e = {1'b0, 1'b1, !(c > 0), c == D + 1, c >= n + 2,
				!(c >= D + 1 - n), !(c >= D / 2 + 2)};
		else
			e = {c > 0, c != D, 1'b1, 1'b0, c >= n + 1,
				!(c >= D - n), !(c >= D / 2 + 1)};
		chk({empty_flag_n, full_flag_n, output_ready_n, input_ready_n,
			almost_empty_n, almost_full_n, half_full_n} === e, "flags");
	endtask
	// fill to capacity, then drain past empty, checking every step
	task automatic run(input logic ft, input logic [2:0] sel, input int n);
		int          cap;
		logic [35:0] b;
		cap = ft ? D + 1 : D;
		b = {1'b1, ft, sel, 31'h0};
		@(posedge mclk);
		#1;
		master_reset_n = 1'b0;
		timing_mode_select_serial_in = ft;
		{offset_default_sel_load, offset_default_sel_hi,
			offset_default_sel_lo} = sel;
		repeat (10) @(posedge mclk);
		#1;
		master_reset_n = 1'b1;
		settle();
		chk(fall_through_mode === ft, "mode");
		chk(write_ready === 1'b1, "write ready after master reset");
		flags(ft, n, 0);
		for (int i = 1; i <= cap; i++)
		begin
			peer.put(b + 36'(i));
			settle();
			flags(ft, n, i);
		end
		// one write too many must be dropped, never stored later
		peer.put(b + 36'(cap + 1));
		settle();
		flags(ft, n, cap);
		for (int i = 1; i <= cap; i++)
		begin
			if (ft)
				chk(output_word === b + 36'(i), "word not shown");
			peer.take();
			settle();
			if (!ft)
				chk(output_word === b + 36'(i), "read word");
			flags(ft, n, cap - i);
		end
		peer.take();
		settle();
		chk(ft ? output_ready_n === 1'b1 : output_word === b + 36'(cap),
			"read while empty");
		flags(ft, n, 0);
		$display("test done: fall-through %0d offset %0d", ft, n);
	endtask
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////
	initial
	begin
		mclk = 1'b0;
		forever #4 mclk = ~mclk;
	end
	initial
	begin
		fail_count = 0;
		tests_run = 0;
		rst = 1'b1;
		master_reset_n = 1'b1;
		timing_mode_select_serial_in = 1'b0;
		{offset_default_sel_load, offset_default_sel_hi} = 2'h0;
		offset_default_sel_lo = 1'b0;
		repeat (6) @(posedge mclk);
		#1;
		rst = 1'b0;
		run(1'b0, 3'h7, 3);
		run(1'b1, 3'h7, 3);
		run(1'b0, 3'h5, 7);
		run(1'b1, 3'h5, 7);
		report_and_stop();
	end
	initial
	begin
		repeat (10000) @(posedge mclk);
		fail_count++;
		$display("unexpected at %0t: watchdog expired", $time);
		report_and_stop();
	end
endmodule

bind dcf_top dcf_check #(.WIDTH(WIDTH)) u_chk (.mclk(mclk), .rst(rst),
	.master_reset_n(master_reset_n), .write_en_n(write_en_n),
	.write_ready(write_ready), .read_en_n(read_en_n),
	.output_word(output_word), .empty_flag_n(empty_flag_n),
	.full_flag_n(full_flag_n), .output_ready_n(output_ready_n),
	.input_ready_n(input_ready_n), .almost_empty_n(almost_empty_n),
	.almost_full_n(almost_full_n), .fall_through_mode(fall_through_mode));
